// ==== core/chtr_regs.v ====
// Overview of operation
// [R1] Command bit 10 enables command path machine.
// [R2] Software spaces command/control rewrites by clocks.
// [R3] No-wait: sent flag; wait: ok or CRC.
// [R4] Capture last response index, bits 5:0.
// [R5] Long response index holds reserved ones.
// [R6] Short: word0 only; long: four words.
// [R7] First bit is MSB; word3 LSB zero.
// [R8] Timeout counter loads in wait/busy; flags zero.
// [R9] Program timeout and length before control.
// [R10] 16-bit length loaded at transfer start.
// [R11] Block-mode length multiple of block length.
// [R12] Control bits: enable, direction, mode, DMA.
// [R13] Enable write starts transfer by direction.
// [R14] Block length code n gives 2^n bytes.
// [R15] Counter decrements; zero ends, sets complete.
// [R16] Read remaining count only after completion.
// [R17] Bits 10:0 sticky, 21:11 live.
// [R18] Sticky flag order bit 0 to 10.
// [R19] Live flag order bit 11 to 21.
// [R20] Wide bus missing start bit sets flag 9.
// [R21] Clear register clears flags written one.
// [R22] Two mask registers, one per request.
// [R23] Mask one passes flag, zero suppresses.
// [R24] Request is OR of masked flags.
`include "chtr_defines.vh"

module chtr_regs #(
  parameter DW = 8
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Synchronous reset, active low
  input wire i_psel, // Bus select
  input wire i_penable, // Bus access phase
  input wire i_pwrite, // Bus write
  input wire [11:0] i_paddr, // Bus byte address
  input wire [31:0] i_pwdata, // Bus write data
  output reg [31:0] o_prdata, // Bus read data
  input wire i_card_clk, // Card bus clock pin
  input wire i_card_busy, // Card busy level pin
  output reg o_cmd_req, // Command send request
  output reg [5:0] o_cmd_index, // Index to send
  input wire i_cmd_sent, // Command shifted out
  input wire i_rsp_valid, // Response received
  input wire i_rsp_crc_ok, // Response CRC good
  input wire [5:0] i_rsp_index, // Response index field
  input wire [127:0] i_rsp_bits, // Response, first bit in MSB
  input wire i_rsp_timeout, // No response in time
  input wire i_dat_valid, // Data byte offered
  input wire [DW-1:0] i_dat, // Data byte
  output reg o_dat_ready, // Buffer can take a byte
  output reg o_out_valid, // Buffered byte valid
  output reg [DW-1:0] o_out, // Buffered byte
  input wire i_out_ready, // Consumer takes byte
  input wire i_blk_crc_ok, // Block CRC passed
  input wire i_blk_crc_err, // Block CRC failed
  input wire i_start_bit_err, // Wide bus start bit missing
  output reg o_dma_req, // DMA service request
  output reg [11:0] o_blk_len, // Block length in bytes
  output reg o_stream, // Stream mode selected
  output reg o_irq_a, // Interrupt request A
  output reg o_irq_b // Interrupt request B
);

  localparam [2:0] C_IDLE = 3'h1;
  localparam [2:0] C_SEND = 3'h2;
  localparam [2:0] C_WAIT = 3'h4;
  localparam [5:0] D_IDLE = 6'h01;
  localparam [5:0] D_WAITS = 6'h02;
  localparam [5:0] D_SEND = 6'h04;
  localparam [5:0] D_WAITR = 6'h08;
  localparam [5:0] D_RECV = 6'h10;
  localparam [5:0] D_BUSY = 6'h20;

  reg [`CHTR_CMD_W-1:0] cmd_q;
  reg [5:0] ridx_q;
  reg [31:0] rsp_q [0:3];
  reg [31:0] tmo_q;
  reg [15:0] len_q;
  reg [`CHTR_DCTL_W-1:0] dctl_q;
  reg [15:0] cnt_q;
  reg [31:0] timer_q;
  reg [`CHTR_STK_W-1:0] stk_q;
  reg [`CHTR_ST_W-1:0] mska_q;
  reg [`CHTR_ST_W-1:0] mskb_q;
  reg [2:0] cst_q;
  reg [5:0] dst_q;
  reg [5:0] dst_d;
  reg [2:0] ck_sync_q;
  reg [1:0] busy_sync_q;
  reg [DW-1:0] buf_q [0:1];
  reg [1:0] fill_q;
  reg [1:0] fill_d;
  reg [`CHTR_STK_W-1:0] set_d;
  reg [31:0] rd_d;

  ///////////////////////////////////////////////////////////////////////
  // Bus decode and pin synchronisers.

  wire wr = i_psel & i_penable & i_pwrite;
  wire rd_setup = i_psel & ~i_penable & ~i_pwrite;
  wire wr_cmd = wr && (i_paddr == `CHTR_OFS_CMD);
  wire wr_dctl = wr && (i_paddr == `CHTR_OFS_DCTL);
  wire wr_clr = wr && (i_paddr == `CHTR_OFS_CLR);
  // The card clock is only sampled; its rising edges pace the timer.
  wire ck_rise = ck_sync_q[1] & ~ck_sync_q[2];
  wire busy = busy_sync_q[1];
  wire dir_rx = dctl_q[`CHTR_DCTL_DIR];

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ck_sync_q <= 3'h0;
      busy_sync_q <= 2'h0;
    end else begin
      ck_sync_q <= {ck_sync_q[1:0], i_card_clk};
      busy_sync_q <= {busy_sync_q[0], i_card_busy};
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Two-entry byte buffer in the data path.

  wire d_moving = |(dst_q & (D_WAITS | D_SEND | D_WAITR | D_RECV));
  wire push = i_dat_valid & o_dat_ready;
  wire pop = o_out_valid & i_out_ready;

  always @* begin
    fill_d = fill_q;
    if (push & ~pop) begin
      fill_d = fill_q + 2'h1;
    end else if (pop & ~push) begin
      fill_d = fill_q - 2'h1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      fill_q <= 2'h0;
      buf_q[0] <= {DW{1'b0}};
      buf_q[1] <= {DW{1'b0}};
      o_dat_ready <= 1'b0;
      o_out_valid <= 1'b0;
      o_out <= {DW{1'b0}};
    end else begin
      fill_q <= fill_d;
      if (pop) begin
        buf_q[0] <= buf_q[1];
      end
      if (push) begin
        buf_q[fill_q[0] ^ pop] <= i_dat;
      end
      // Ready is registered, so it looks at the next fill level and
      // the next state; a full buffer stalls the source.
      o_dat_ready <= (fill_d != 2'h2) &&
        |(dst_d & (D_WAITS | D_SEND | D_WAITR | D_RECV));
      o_out_valid <= (fill_d != 2'h0);
      if (pop) begin
        o_out <= (fill_q == 2'h2 || push) ?
          (fill_q == 2'h2 ? buf_q[1] : i_dat) : o_out;
      end else if (push && fill_q == 2'h0) begin
        o_out <= i_dat;
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Data path machine, byte counter and timeout.

  wire last = push && (cnt_q == 16'h0001);
  wire tmo_hit = (timer_q == `CHTR_RST_32) &&
    |(dst_q & (D_WAITR | D_BUSY)); // [R8]

  always @* begin
    dst_d = dst_q;
    case (dst_q)
      D_IDLE: begin
        if (wr_dctl && i_pwdata[`CHTR_DCTL_EN] &&
            i_pwdata[15:0] != 16'h0 && len_q != `CHTR_RST_16) begin
          dst_d = i_pwdata[`CHTR_DCTL_DIR] ? D_WAITR : D_WAITS; // [R13]
        end
      end
      D_WAITS, D_SEND: begin
        if (last) begin
          dst_d = D_BUSY;
        end else if (push) begin
          dst_d = D_SEND;
        end
      end
      D_WAITR, D_RECV: begin
        if (last || tmo_hit) begin
          dst_d = D_IDLE; // [R15]
        end else if (push) begin
          dst_d = D_RECV;
        end
      end
      D_BUSY: begin
        if (!busy || tmo_hit) begin
          dst_d = D_IDLE;
        end
      end
      default: begin
        dst_d = D_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      dst_q <= D_IDLE;
      cnt_q <= `CHTR_RST_16;
      timer_q <= `CHTR_RST_32;
    end else begin
      dst_q <= dst_d;
      if (dst_q == D_IDLE && dst_d != D_IDLE) begin
        cnt_q <= len_q; // [R10] [R15]
      end else if (push && d_moving) begin
        cnt_q <= cnt_q - 16'h0001; // [R15]
      end
      if ((dst_d == D_WAITR && dst_q != D_WAITR) ||
          (dst_d == D_BUSY && dst_q != D_BUSY)) begin
        timer_q <= tmo_q; // [R8]
      end else if (ck_rise && timer_q != `CHTR_RST_32) begin
        timer_q <= timer_q - 32'h1; // [R8]
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Command path machine and response capture.

  // A write that sets or clears the enable acts in its own cycle, so a
  // start from the disabled state is not lost to the stale enable.
  wire cmd_en = wr_cmd ? i_pwdata[`CHTR_CMD_EN] : cmd_q[`CHTR_CMD_EN];

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cst_q <= C_IDLE;
      o_cmd_req <= 1'b0;
      o_cmd_index <= 6'h0;
      ridx_q <= 6'h0;
      rsp_q[0] <= `CHTR_RST_32;
      rsp_q[1] <= `CHTR_RST_32;
      rsp_q[2] <= `CHTR_RST_32;
      rsp_q[3] <= `CHTR_RST_32;
    end else if (!cmd_en) begin
      cst_q <= C_IDLE; // [R1]
      o_cmd_req <= 1'b0;
    end else begin
      case (cst_q)
        C_IDLE: begin
          if (wr_cmd && i_pwdata[`CHTR_CMD_EN]) begin
            cst_q <= C_SEND; // [R1]
            o_cmd_req <= 1'b1;
            o_cmd_index <= i_pwdata[`CHTR_CMD_IDX];
          end
        end
        C_SEND: begin
          if (i_cmd_sent) begin
            o_cmd_req <= 1'b0;
            cst_q <= cmd_q[`CHTR_CMD_RESP] ? C_WAIT : C_IDLE; // [R3]
          end
        end
        C_WAIT: begin
          if (i_rsp_valid) begin
            cst_q <= C_IDLE;
            // A long reply carries the reserved all-ones field here.
            ridx_q <= i_rsp_index; // [R4] [R5]
            if (cmd_q[`CHTR_CMD_LONG]) begin
              rsp_q[0] <= i_rsp_bits[127:96]; // [R6] [R7]
              rsp_q[1] <= i_rsp_bits[95:64];
              rsp_q[2] <= i_rsp_bits[63:32];
              rsp_q[3] <= {i_rsp_bits[31:1], 1'b0}; // [R7]
            end else begin
              rsp_q[0] <= i_rsp_bits[31:0]; // [R6]
            end
          end else if (i_rsp_timeout) begin
            cst_q <= C_IDLE;
          end
        end
        default: begin
          cst_q <= C_IDLE;
        end
      endcase
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Status flags.

  wire cmd_live = cmd_q[`CHTR_CMD_EN];
  wire [`CHTR_ST_W-1:0] status;
  wire tx_on = |(dst_q & (D_WAITS | D_SEND | D_BUSY));
  wire rx_on = |(dst_q & (D_WAITR | D_RECV));
  wire q_empty = (fill_q == 2'h0);
  wire q_full = (fill_q == 2'h2);

  always @* begin
    set_d = {`CHTR_STK_W{1'b0}};
    set_d[`CHTR_F_CCRC] = cmd_live && cst_q == C_WAIT &&
      i_rsp_valid && !i_rsp_crc_ok; // [R3]
    set_d[`CHTR_F_COK] = cmd_live && cst_q == C_WAIT &&
      i_rsp_valid && i_rsp_crc_ok; // [R3]
    set_d[`CHTR_F_CTMO] = cmd_live && cst_q == C_WAIT &&
      !i_rsp_valid && i_rsp_timeout;
    set_d[`CHTR_F_CSENT] = cmd_live && cst_q == C_SEND &&
      i_cmd_sent && !cmd_q[`CHTR_CMD_RESP]; // [R3]
    set_d[`CHTR_F_DCRC] = i_blk_crc_err;
    set_d[`CHTR_F_BEND] = i_blk_crc_ok;
    set_d[`CHTR_F_DTMO] = tmo_hit; // [R8]
    set_d[`CHTR_F_TXUR] = (dst_q == D_SEND) && i_out_ready && q_empty;
    // A receiving card cannot be stalled, so a refused byte is lost.
    set_d[`CHTR_F_RXOR] = rx_on && i_dat_valid && !o_dat_ready;
    set_d[`CHTR_F_DEND] = (dst_q != D_IDLE && dst_d == D_IDLE &&
      !tmo_hit) || (dst_q == D_IDLE && wr_dctl &&
      i_pwdata[`CHTR_DCTL_EN] && len_q == `CHTR_RST_16); // [R15]
    set_d[`CHTR_F_SBE] = i_start_bit_err; // [R20]
  end

  assign status = {
    ~q_empty & rx_on, ~q_empty & tx_on, // [R19]
    q_empty & rx_on, q_empty & tx_on,
    q_full & rx_on, q_full & tx_on,
    ~q_empty & rx_on, (fill_q != 2'h2) & tx_on,
    rx_on, tx_on, cst_q != C_IDLE,
    stk_q // [R17] [R18]
  };

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      stk_q <= {`CHTR_STK_W{1'b0}};
    end else if (wr_clr) begin
      // A flag raised in the clearing cycle survives the clear.
      stk_q <= (stk_q & ~i_pwdata[`CHTR_STK_W-1:0]) | set_d; // [R21]
    end else begin
      stk_q <= stk_q | set_d; // [R17]
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Register writes, reads and registered outputs.

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmd_q <= {`CHTR_CMD_W{1'b0}};
      tmo_q <= `CHTR_RST_32;
      len_q <= `CHTR_RST_16;
      dctl_q <= {`CHTR_DCTL_W{1'b0}};
      mska_q <= {`CHTR_ST_W{1'b0}};
      mskb_q <= {`CHTR_ST_W{1'b0}};
    end else if (wr) begin
      if (i_paddr == `CHTR_OFS_CMD) begin
        cmd_q <= i_pwdata[`CHTR_CMD_W-1:0]; // [R1]
      end else if (i_paddr == `CHTR_OFS_TMO) begin
        tmo_q <= i_pwdata;
      end else if (i_paddr == `CHTR_OFS_LEN) begin
        len_q <= i_pwdata[15:0]; // [R10]
      end else if (i_paddr == `CHTR_OFS_DCTL) begin
        dctl_q <= i_pwdata[`CHTR_DCTL_W-1:0]; // [R12]
      end else if (i_paddr == `CHTR_OFS_MSKA) begin
        mska_q <= i_pwdata[`CHTR_ST_W-1:0]; // [R22]
      end else if (i_paddr == `CHTR_OFS_MSKB) begin
        mskb_q <= i_pwdata[`CHTR_ST_W-1:0]; // [R22]
      end
    end
  end

  // Remaining count is only meaningful once the transfer has ended.
  always @* begin
    rd_d = `CHTR_RST_32;
    if (i_paddr == `CHTR_OFS_CMD) begin
      rd_d[`CHTR_CMD_W-1:0] = cmd_q;
    end else if (i_paddr == `CHTR_OFS_RIDX) begin
      rd_d[5:0] = ridx_q; // [R4]
    end else if (i_paddr == `CHTR_OFS_RSP0) begin
      rd_d = rsp_q[0];
    end else if (i_paddr == `CHTR_OFS_RSP1) begin
      rd_d = rsp_q[1];
    end else if (i_paddr == `CHTR_OFS_RSP2) begin
      rd_d = rsp_q[2];
    end else if (i_paddr == `CHTR_OFS_RSP3) begin
      rd_d = rsp_q[3];
    end else if (i_paddr == `CHTR_OFS_TMO) begin
      rd_d = tmo_q;
    end else if (i_paddr == `CHTR_OFS_LEN) begin
      rd_d[15:0] = len_q;
    end else if (i_paddr == `CHTR_OFS_DCTL) begin
      rd_d[`CHTR_DCTL_W-1:0] = dctl_q;
    end else if (i_paddr == `CHTR_OFS_DCNT) begin
      rd_d[15:0] = cnt_q; // [R16]
    end else if (i_paddr == `CHTR_OFS_STAT) begin
      rd_d[`CHTR_ST_W-1:0] = status; // [R17]
    end else if (i_paddr == `CHTR_OFS_MSKA) begin
      rd_d[`CHTR_ST_W-1:0] = mska_q;
    end else if (i_paddr == `CHTR_OFS_MSKB) begin
      rd_d[`CHTR_ST_W-1:0] = mskb_q;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= `CHTR_RST_32;
      o_irq_a <= 1'b0;
      o_irq_b <= 1'b0;
      o_dma_req <= 1'b0;
      o_blk_len <= 12'h0;
      o_stream <= 1'b0;
    end else begin
      if (rd_setup) begin
        o_prdata <= rd_d;
      end
      o_irq_a <= |(status & mska_q); // [R23] [R24]
      o_irq_b <= |(status & mskb_q); // [R23] [R24]
      o_dma_req <= dctl_q[`CHTR_DCTL_DMA] && // [R12]
        (dir_rx ? (fill_d != 2'h0) : (fill_d != 2'h2)) &&
        (dst_d != D_IDLE);
      // Reserved codes give a zero length rather than wrapping.
      o_blk_len <= (dctl_q[`CHTR_DCTL_BLK] > `CHTR_BLK_MAX) ? 12'h0 :
        (12'h1 << dctl_q[`CHTR_DCTL_BLK]); // [R14]
      o_stream <= dctl_q[`CHTR_DCTL_MODE]; // [R12]
    end
  end

endmodule // chtr_regs

// ==== core/chtr_defines.vh ====
`ifndef CHTR_DEFINES_VH
`define CHTR_DEFINES_VH

// Register byte offsets on the peripheral bus.
`define CHTR_OFS_CMD 12'h00c
`define CHTR_OFS_RIDX 12'h010
`define CHTR_OFS_RSP0 12'h014
`define CHTR_OFS_RSP1 12'h018
`define CHTR_OFS_RSP2 12'h01c
`define CHTR_OFS_RSP3 12'h020
`define CHTR_OFS_TMO 12'h024
`define CHTR_OFS_LEN 12'h028
`define CHTR_OFS_DCTL 12'h02c
`define CHTR_OFS_DCNT 12'h030
`define CHTR_OFS_STAT 12'h034
`define CHTR_OFS_CLR 12'h038
`define CHTR_OFS_MSKA 12'h03c
`define CHTR_OFS_MSKB 12'h040

// Command register fields.
`define CHTR_CMD_W 11
`define CHTR_CMD_IDX 5:0
`define CHTR_CMD_RESP 6
`define CHTR_CMD_LONG 7
`define CHTR_CMD_EN 10

// Data control fields.
`define CHTR_DCTL_W 8
`define CHTR_DCTL_EN 0
`define CHTR_DCTL_DIR 1
`define CHTR_DCTL_MODE 2
`define CHTR_DCTL_DMA 3
`define CHTR_DCTL_BLK 7:4
`define CHTR_BLK_MAX 4'hb

// Status bit positions.
`define CHTR_ST_W 22
`define CHTR_STK_W 11
`define CHTR_F_CCRC 0
`define CHTR_F_DCRC 1
`define CHTR_F_CTMO 2
`define CHTR_F_DTMO 3
`define CHTR_F_TXUR 4
`define CHTR_F_RXOR 5
`define CHTR_F_COK 6
`define CHTR_F_CSENT 7
`define CHTR_F_DEND 8
`define CHTR_F_SBE 9
`define CHTR_F_BEND 10

// Reset values.
`define CHTR_RST_32 32'h0000_0000
`define CHTR_RST_16 16'h0000

`endif

// ==== sim/chtr_properties.sv ====
`include "chtr_defines.vh"
module chtr_properties #(
  parameter int DW = 8
) (
  input logic i_clk, // System clock
  input logic i_rst_n, // Sync reset
  input logic i_psel, // Bus select
  input logic i_penable, // Access phase
  input logic i_pwrite, // Bus write
  input logic [11:0] i_paddr, // Address
  input logic [31:0] i_pwdata, // Write data
  input logic [31:0] o_prdata, // Read data
  input logic o_cmd_req, // Command request
  input logic i_cmd_sent, // Command sent
  input logic o_out_valid, // Buffer valid
  input logic [DW-1:0] o_out, // Buffer byte
  input logic i_out_ready, // Consumer ready
  input logic [11:0] o_blk_len, // Block bytes
  input logic o_stream, // Stream mode
  input logic o_irq_a // Request A
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr, rd, mza_q;
  assign wr = i_psel & i_penable & i_pwrite;
  assign rd = i_psel & !i_penable & !i_pwrite;
  // The mask resets to zero, so the tracker starts out set.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      mza_q <= 1'b1;
    end else if (wr && i_paddr == `CHTR_OFS_MSKA) begin
      mza_q <= ~|i_pwdata[21:0];
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  cmd_drop_a: assert property (
    o_cmd_req && i_cmd_sent |=> !o_cmd_req)
    else $error("command request outlived sent pulse");
  cmd_off_a: assert property (
    wr && i_paddr == `CHTR_OFS_CMD && !i_pwdata[10] |=> !o_cmd_req)
    else $error("command request while path disabled");
  // The length output follows the stored control word one cycle late.
  blk_len_a: assert property (
    wr && i_paddr == `CHTR_OFS_DCTL && i_pwdata[7:4] < 4'hc
    |=> ##1 o_blk_len == (12'h001 << $past(i_pwdata[7:4], 2)))
    else $error("block length wrong");
  blk_rsv_a: assert property (
    wr && i_paddr == `CHTR_OFS_DCTL && i_pwdata[7:4] > 4'hb
    |=> ##1 o_blk_len == 12'h000)
    else $error("reserved block code not zero");
  mode_bit_a: assert property (
    wr && i_paddr == `CHTR_OFS_DCTL
    |=> ##1 o_stream == $past(i_pwdata[2], 2))
    else $error("mode bit not followed");
  idx_rd_a: assert property (
    rd && i_paddr == `CHTR_OFS_RIDX |=> o_prdata[31:6] == 26'h0)
    else $error("reply index wider than six bits");
  rsp3_lsb_a: assert property (
    rd && i_paddr == `CHTR_OFS_RSP3 |=> !o_prdata[0])
    else $error("last reply word low bit set");
  clr_rd_a: assert property (
    rd && i_paddr == `CHTR_OFS_CLR |=> o_prdata == 32'h0)
    else $error("clear register readable");
  irq_mask_a: assert property (
    mza_q |=> !o_irq_a)
    else $error("request raised with empty mask");
  buf_hold_a: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
    else $error("stalled byte lost or changed");
endmodule // chtr_properties

// ==== sim/chtr_card_model.sv ====
module chtr_card_model (
  input logic i_clk, // System clock
  input logic i_run, // Card clock runs
  input logic i_cmd_req, // Command request
  input logic [5:0] i_cmd_index, // Command index
  input logic i_resp, // Reply expected
  input logic i_long, // Long reply
  input logic i_bad, // Corrupt reply CRC
  input logic i_tmo, // Give no reply
  output logic o_card_clk, // Card clock
  output logic o_card_busy, // Card busy
  output logic o_cmd_sent, // Command sent
  output logic o_rsp_valid, // Reply strobe
  output logic o_rsp_crc_ok, // Reply CRC good
  output logic [5:0] o_rsp_index, // Reply index
  output logic [127:0] o_rsp_bits, // Reply bits
  output logic o_rsp_timeout // Reply timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] PAT =
    128'h8badf00d_1234abcd_0f1e2d3c_c3b2a195;
  logic [5:0] idx_v;
  assign idx_v = i_long ? 6'h3f : i_cmd_index;
  // Off the strobe the lines show the inverse, so a late capture fails.
  assign o_rsp_index = o_rsp_valid ? idx_v : ~idx_v;
  assign o_rsp_bits = o_rsp_valid ? PAT : ~PAT;
  assign o_rsp_crc_ok = o_rsp_valid ? !i_bad : i_bad;
  assign o_card_busy = 1'b0;
  // The card clock stands still at zero while i_run is low.
  initial begin
    o_card_clk = 1'b0;
    #1;
    forever begin
      #40;
      o_card_clk = i_run ? ~o_card_clk : 1'b0;
    end
  end
  initial begin
    {o_cmd_sent, o_rsp_valid, o_rsp_timeout} = 3'b000;
    forever begin
      @(posedge i_clk);
      if (i_cmd_req) begin
        repeat (3) @(posedge i_clk);
        o_cmd_sent <= 1'b1;
        @(posedge i_clk);
        o_cmd_sent <= 1'b0;
        if (i_resp) begin
          repeat (4) @(posedge i_clk);
          o_rsp_valid <= !i_tmo;
          o_rsp_timeout <= i_tmo;
          @(posedge i_clk);
          {o_rsp_valid, o_rsp_timeout} <= 2'b00;
        end
      end
    end
  end
endmodule // chtr_card_model

// ==== sim/card_host_transfer_registers_test.sv ====
`include "chtr_defines.vh"
module card_host_transfer_registers_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_card_clk;
  logic i_card_busy, o_cmd_req, i_cmd_sent, i_rsp_valid, i_rsp_crc_ok;
  logic [11:0] i_paddr, o_blk_len;
  logic [31:0] i_pwdata, o_prdata;
  logic [5:0] o_cmd_index, i_rsp_index;
  logic [127:0] i_rsp_bits;
  logic i_rsp_timeout, i_dat_valid, o_dat_ready, o_out_valid, i_out_ready;
  logic [7:0] i_dat, o_out;
  logic i_blk_crc_ok, i_blk_crc_err, i_start_bit_err, o_stream, o_dma_req;
  logic o_irq_a, o_irq_b, m_run, m_resp, m_long, m_bad, m_tmo;
  int n_fail = 0, check_count = 0, cycles = 0;
  chtr_regs #(.DW(8)) dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .i_card_clk, .i_card_busy, .o_cmd_req,
    .o_cmd_index, .i_cmd_sent, .i_rsp_valid, .i_rsp_crc_ok, .i_rsp_index,
    .i_rsp_bits, .i_rsp_timeout, .i_dat_valid, .i_dat, .o_dat_ready,
    .o_out_valid, .o_out, .i_out_ready, .i_blk_crc_ok, .i_blk_crc_err,
    .i_start_bit_err, .o_dma_req, .o_blk_len, .o_stream, .o_irq_a, .o_irq_b);
  chtr_card_model card (.i_clk, .i_run(m_run), .i_cmd_req(o_cmd_req),
    .i_cmd_index(o_cmd_index), .i_resp(m_resp), .i_long(m_long),
    .i_bad(m_bad), .i_tmo(m_tmo), .o_card_clk(i_card_clk),
    .o_card_busy(i_card_busy), .o_cmd_sent(i_cmd_sent),
    .o_rsp_valid(i_rsp_valid), .o_rsp_crc_ok(i_rsp_crc_ok),
    .o_rsp_index(i_rsp_index), .o_rsp_bits(i_rsp_bits),
    .o_rsp_timeout(i_rsp_timeout));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a,
                     inout logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite} <= 3'b000;
    d = wr ? d : o_prdata;
  endtask
  task automatic bw(input logic [11:0] a, input logic [31:0] w);
    bus(1'b1, a, w);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    d = 32'h0;
    bus(1'b0, a, d);
    chk(d, e);
  endtask
  task automatic rs(input logic [31:0] e);
    logic [31:0] d;
    d = 32'h0;
    bus(1'b0, `CHTR_OFS_STAT, d);
    chk(d & 32'h7ff, e);
  endtask
  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge i_clk);
    while (o_dat_ready !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    i_dat_valid <= 1'b1;
    i_dat <= b;
    @(posedge i_clk);
    i_dat_valid <= 1'b0;
    i_dat <= ~b;
  endtask
  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    @(posedge i_clk);
    i_out_ready <= 1'b1;
    @(posedge i_clk);
    while (o_out_valid !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_out, e);
    i_out_ready <= 1'b0;
  endtask
  task automatic t_regs;
    for (int a = 12; a <= 64; a += 4) rc(a[11:0], 32'h0);
    rc(12'h04c, 32'h0);
    bw(`CHTR_OFS_TMO, 32'hffff_ffff);
    rc(`CHTR_OFS_TMO, 32'hffff_ffff);
    bw(`CHTR_OFS_LEN, 32'hffff_ffff);
    rc(`CHTR_OFS_LEN, 32'h0000_ffff);
    bw(`CHTR_OFS_DCTL, 32'h0000_00fe);
    rc(`CHTR_OFS_DCTL, 32'h0000_00fe);
    chk(o_blk_len, 32'h0);
    chk(o_stream, 32'h1);
    bw(`CHTR_OFS_CMD, 32'h0000_033f);
    rc(`CHTR_OFS_CMD, 32'h0000_033f);
    bw(`CHTR_OFS_MSKB, 32'hffff_ffff);
    rc(`CHTR_OFS_MSKB, 32'h003f_ffff);
    bw(`CHTR_OFS_STAT, 32'hffff_ffff);
    bw(`CHTR_OFS_CLR, 32'hffff_ffff);
    bw(12'h04c, 32'hffff_ffff);
    rc(`CHTR_OFS_STAT, 32'h0);
    rc(12'h04c, 32'h0);
    bw(`CHTR_OFS_MSKB, 32'h0);
  endtask
  task automatic t_flags;
    @(posedge i_clk);
    {i_start_bit_err, i_blk_crc_ok} <= 2'b11;
    @(posedge i_clk);
    {i_start_bit_err, i_blk_crc_ok} <= 2'b00;
    rs(32'h600);
    bw(`CHTR_OFS_CLR, 32'h200);
    rs(32'h400);
    i_blk_crc_err <= 1'b1;
    @(posedge i_clk);
    i_blk_crc_err <= 1'b0;
    rs(32'h402);
    bw(`CHTR_OFS_CLR, 32'h7ff);
    rs(32'h0);
  endtask
  task automatic t_cmd;
    logic [3:0] cfg [5] = '{4'h4, 4'h8, 4'hc, 4'ha, 4'h9};
    logic [10:0] ex [5] = '{11'h080, 11'h040, 11'h040, 11'h001, 11'h004};
    for (int k = 0; k < 5; k++) begin
      {m_resp, m_long, m_bad, m_tmo} <= cfg[k];
      bw(`CHTR_OFS_CMD, {24'h4, cfg[k][2], cfg[k][3], 6'h11 + 6'(k)});
      // The index register loads on the write edge; look one edge on.
      @(posedge i_clk);
      chk(o_cmd_index, 6'h11 + 6'(k));
      repeat (20) @(posedge i_clk);
      rs({21'h0, ex[k]});
      if (k == 1) begin
        rc(`CHTR_OFS_RSP0, 32'hc3b2a195);
        rc(`CHTR_OFS_RIDX, 32'h12);
      end
      if (k == 2) begin
        rc(`CHTR_OFS_RSP0, 32'h8badf00d);
        rc(`CHTR_OFS_RSP1, 32'h1234abcd);
        rc(`CHTR_OFS_RSP2, 32'h0f1e2d3c);
        rc(`CHTR_OFS_RSP3, 32'hc3b2a194);
        rc(`CHTR_OFS_RIDX, 32'h3f);
      end
      bw(`CHTR_OFS_CLR, 32'h7ff);
    end
  endtask
  task automatic t_rx;
    logic [31:0] d;
    d = 32'h0;
    bw(`CHTR_OFS_TMO, 32'hffff);
    bw(`CHTR_OFS_LEN, 32'h4);
    bw(`CHTR_OFS_DCTL, 32'h2b);
    // Control lands on the write edge, the length output one edge later.
    repeat (2) @(posedge i_clk);
    chk(o_blk_len, 32'h4);
    push(8'ha0);
    push(8'ha1);
    @(posedge i_clk);
    chk(o_dat_ready, 32'h0);
    chk(o_dma_req, 32'h1);
    bus(1'b0, `CHTR_OFS_STAT, d);
    chk(d[21:11], 32'h454);
    pop(8'ha0);
    pop(8'ha1);
    push(8'ha2);
    push(8'ha3);
    pop(8'ha2);
    pop(8'ha3);
    rs(32'h100);
    rc(`CHTR_OFS_DCNT, 32'h0);
    bw(`CHTR_OFS_MSKA, 32'h100);
    repeat (2) @(posedge i_clk);
    chk(o_irq_a, 32'h1);
    chk(o_irq_b, 32'h0);
    bw(`CHTR_OFS_CLR, 32'h100);
    repeat (2) @(posedge i_clk);
    chk(o_irq_a, 32'h0);
    bw(`CHTR_OFS_MSKA, 32'h0);
  endtask
  // Host to card: the last byte leads through busy back to idle.
  task automatic t_tx;
    bw(`CHTR_OFS_LEN, 32'h2);
    bw(`CHTR_OFS_DCTL, 32'h1);
    push(8'hb0);
    push(8'hb1);
    chk(o_dma_req, 32'h0);
    pop(8'hb0);
    pop(8'hb1);
    rs(32'h100);
    rc(`CHTR_OFS_DCNT, 32'h0);
    bw(`CHTR_OFS_CLR, 32'h100);
  endtask
  task automatic t_tmo;
    logic [31:0] d;
    int n;
    {d, n} = '0;
    bw(`CHTR_OFS_TMO, 32'h3);
    bw(`CHTR_OFS_DCTL, 32'h3);
    m_run <= 1'b1;
    repeat (10) @(posedge i_clk);
    rs(32'h0);
    while (d[3] !== 1'b1 && n < 60) begin
      bus(1'b0, `CHTR_OFS_STAT, d);
      n++;
    end
    chk(d & 32'h7ff, 32'h8);
    m_run <= 1'b0;
  endtask
  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_dat_valid,
     i_dat, i_out_ready, i_blk_crc_ok, i_blk_crc_err, i_start_bit_err,
     m_run, m_resp, m_long, m_bad, m_tmo} = '0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs;
    t_flags;
    t_cmd;
    t_rx;
    t_tx;
    t_tmo;
    close_out;
  end
endmodule // card_host_transfer_registers_test
bind chtr_regs chtr_properties #(.DW(DW)) u_props (.i_clk, .i_rst_n,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_cmd_req,
  .i_cmd_sent, .o_out_valid, .o_out, .i_out_ready, .o_blk_len, .o_stream,
  .o_irq_a);
